// file: rtl/ahs_params.svh
// constants for the arbiter host side interface
`ifndef AHS_PARAMS_SVH
`define AHS_PARAMS_SVH

// --------------------------------------------------------------------
// register bank geometry and reset value
// --------------------------------------------------------------------
`define AHS_ADDR_W 4
`define AHS_DATA_W 8
`define AHS_REG_RST 8'h00

// --------------------------------------------------------------------
// status byte overlaid on the top register index for reads
// --------------------------------------------------------------------
`define AHS_STATUS_IDX 4'hf
`define AHS_STAT_MASTER_BIT 0
`define AHS_STAT_COMPETED_BIT 1
`define AHS_STAT_PENDING_BIT 2
`define AHS_STAT_PHASE0_BIT 3

`endif

// file: rtl/ahs_pkg.sv
// types for the arbiter host side interface
package ahs_pkg;

    // host access sequencer states, one-hot
    typedef enum logic [2:0] {
        AHS_ST_IDLE  = 3'b001,
        AHS_ST_FETCH = 3'b010,
        AHS_ST_ACK   = 3'b100
    } ahs_acc_st_t;

endpackage : ahs_pkg

// file: rtl/ahs_reg_mem.sv
// small register bank memory with registered read data
`timescale 1ns/100ps
`default_nettype none
`include "ahs_params.svh"

module ahs_reg_mem
    import ahs_pkg::*;
#(
    parameter int AW = `AHS_ADDR_W,
    parameter int DW = `AHS_DATA_W
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [DW-1:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [DW-1:0] rd_data_o
);

    localparam int DEPTH = 1 << AW;

    logic [DW-1:0] mem [DEPTH];

    // --------------------------------------------------------------------
    // storage
    // --------------------------------------------------------------------
    // write port, cleared on reset
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= `AHS_REG_RST;
            end
        end else if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    // registered read port
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_data_o <= `AHS_REG_RST;
        end else if (rd_en_i) begin
            rd_data_o <= mem[rd_addr_i];
        end
    end

endmodule // ahs_reg_mem
`default_nettype wire

// file: rtl/ahs_host_if.sv
// host and external logic side of the backplane arbitration controller
// Function
// RULE_01: register bank reached over eight-bit data bus, driven on reads, sampled on writes
// RULE_02: host presents a four-bit register index during each access
// RULE_03: access starts on chip select; device answers only while it is asserted
// RULE_04: data acknowledge asserted for every completed read or write
// RULE_05: select high captures on chip select rise, low on acknowledge fall
// RULE_06: message send request makes the device arbitrate to send a message
// RULE_07: message sent flag only after a successful message transmission
// RULE_08: error interrupt asserted on any arbitration cycle error
// RULE_09: message interrupt asserted when an arbitration message is received
// RULE_10: powerfail interrupt asserted when the received message is powerfail
// RULE_11: idle compete window asserted while competing in idle bus arbitration
// RULE_12: idle success after competing makes this module the bus master
// RULE_13: idle success while master without competing clears the master flag
// RULE_14: outside logic asserts disconnect or abort to cancel the cycle
// RULE_15: locked at tenure transfer gives dummy cycle if master, else unlock
// RULE_16: unlock output never asserted unless resources locked is asserted
// RULE_17: queue strobe pulsed for each received arbitration message
// RULE_18: all timing derived from one clock input
// RULE_19: host reset clears state, releases outputs, returns to phase zero
// RULE_20: pending interrupt outputs cleared by a host register write
// RULE_21: acknowledge negated after chip select negates, before next access
`timescale 1ns/100ps
`default_nettype none
`include "ahs_params.svh"

module ahs_host_if
    import ahs_pkg::*;
#(
    parameter int AW = `AHS_ADDR_W,
    parameter int DW = `AHS_DATA_W
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic host_rst_n_i,
    input wire logic [DW-1:0] data_i,
    output logic [DW-1:0] data_o,
    output logic data_oe_o,
    input wire logic [AW-1:0] addr_i,
    input wire logic cs_n_i,
    input wire logic rw_n_i,
    output logic transfer_ack_n_o,
    input wire logic capture_sel_i,
    input wire logic message_send_request_n_i,
    output logic msg_tx_req_o,
    input wire logic msg_tx_done_i,
    output logic message_sent_flag_n_o,
    input wire logic arb_error_i,
    output logic arbitration_error_irq_n_o,
    input wire logic msg_rx_valid_i,
    input wire logic msg_rx_powerfail_i,
    output logic message_received_irq_n_o,
    output logic powerfail_message_irq_n_o,
    output logic message_queue_strobe_n_o,
    input wire logic idle_arb_active_i,
    input wire logic idle_compete_request_n_i,
    output logic idle_compete_window_n_o,
    input wire logic idle_win_success_n_i,
    input wire logic disconnect_or_abort_i,
    input wire logic tenure_transfer_i,
    input wire logic resources_locked_in_n_i,
    output logic release_locks_out_n_o,
    output logic dummy_cycle_o,
    output logic master_o,
    output logic phase0_o
);

    ahs_acc_st_t st;
    ahs_acc_st_t next_st;
    logic [AW-1:0] addr_q;
    logic rd_q;
    logic wr_pulse;
    logic [DW-1:0] wr_data;
    logic [DW-1:0] mem_rd;
    logic [DW-1:0] status;
    logic rd_en;
    logic competed;
    logic win_prev;
    logic win_fall;
    logic msg_pend;
    logic soft_rst;

    assign soft_rst = ~host_rst_n_i; // RULE_19

    // --------------------------------------------------------------------
    // host access sequencer
    // --------------------------------------------------------------------
    // next state of the access handshake
    always_comb begin
        next_st = st;
        unique case (st)
            AHS_ST_IDLE: begin
                if (!cs_n_i) begin // RULE_03
                    next_st = AHS_ST_FETCH;
                end
            end
            AHS_ST_FETCH: begin
                if (cs_n_i) begin
                    next_st = AHS_ST_IDLE;
                end else begin
                    next_st = AHS_ST_ACK; // RULE_04
                end
            end
            AHS_ST_ACK: begin
                if (cs_n_i) begin
                    next_st = AHS_ST_IDLE; // RULE_21
                end
            end
            default: begin
                next_st = AHS_ST_IDLE;
            end
        endcase
    end

    // state register; one clock drives everything
    always_ff @(posedge clk_i or posedge sys_rst_i) begin // RULE_18
        if (sys_rst_i) begin
            st <= AHS_ST_IDLE;
        end else if (soft_rst) begin
            st <= AHS_ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // latch index and direction at the start of an access
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            addr_q <= '0;
            rd_q <= 1'b0;
        end else if (st == AHS_ST_IDLE && !cs_n_i) begin
            addr_q <= addr_i; // RULE_02
            rd_q <= rw_n_i;
        end
    end

    // acknowledge is the ack state itself
    assign transfer_ack_n_o = (st != AHS_ST_ACK); // RULE_04

    // write strobe on the selected capture edge
    always_comb begin
        wr_pulse = 1'b0;
        if (!rd_q && !soft_rst) begin
            if (capture_sel_i) begin
                wr_pulse = (st == AHS_ST_ACK) && cs_n_i; // RULE_05
            end else begin
                wr_pulse = (st == AHS_ST_FETCH) && !cs_n_i; // RULE_05
            end
        end
    end
    assign wr_data = data_i; // RULE_01

    assign rd_en = (st == AHS_ST_IDLE) && !cs_n_i && rw_n_i;

    ahs_reg_mem #(
        .AW(AW),
        .DW(DW)
    ) u_mem (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_en_i(wr_pulse),
        .wr_addr_i(addr_q),
        .wr_data_i(wr_data),
        .rd_en_i(rd_en),
        .rd_addr_i(addr_i),
        .rd_data_o(mem_rd)
    );

    // status byte seen at the top index
    always_comb begin
        status = '0;
        status[`AHS_STAT_MASTER_BIT] = master_o;
        status[`AHS_STAT_COMPETED_BIT] = competed;
        status[`AHS_STAT_PENDING_BIT] = msg_pend;
        status[`AHS_STAT_PHASE0_BIT] = phase0_o;
    end

    // read data and bus drive, released outside read acks
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            data_o <= '0;
            data_oe_o <= 1'b0;
        end else if (soft_rst) begin
            data_oe_o <= 1'b0; // RULE_19
        end else if (st == AHS_ST_FETCH && !cs_n_i && rd_q) begin
            data_o <= (addr_q == `AHS_STATUS_IDX) ? status : mem_rd;
            data_oe_o <= 1'b1; // RULE_01
        end else if (next_st != AHS_ST_ACK) begin
            data_oe_o <= 1'b0;
        end
    end

    // --------------------------------------------------------------------
    // message send and arbitration events
    // --------------------------------------------------------------------
    // pending send request until sent or cancelled
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            msg_pend <= 1'b0;
        end else if (soft_rst || disconnect_or_abort_i) begin
            msg_pend <= 1'b0; // RULE_14
        end else if (!message_send_request_n_i) begin
            msg_pend <= 1'b1; // RULE_06
        end else if (msg_tx_done_i) begin
            msg_pend <= 1'b0;
        end
    end
    assign msg_tx_req_o = msg_pend; // RULE_06

    // phase zero held from reset until a send begins
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            phase0_o <= 1'b1;
        end else if (soft_rst) begin
            phase0_o <= 1'b1; // RULE_19
        end else if (msg_pend || !transfer_ack_n_o) begin
            phase0_o <= phase0_o & ~msg_pend;
        end else begin
            phase0_o <= ~msg_pend;
        end
    end

    // sent flag pulses once per successful transmission
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            message_sent_flag_n_o <= 1'b1;
        end else begin
            message_sent_flag_n_o <= ~(msg_tx_done_i && msg_pend &&
                !soft_rst); // RULE_07
        end
    end

    // sticky interrupts, set wins over the write clear
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            arbitration_error_irq_n_o <= 1'b1;
            message_received_irq_n_o <= 1'b1;
            powerfail_message_irq_n_o <= 1'b1;
        end else if (soft_rst) begin
            arbitration_error_irq_n_o <= 1'b1;
            message_received_irq_n_o <= 1'b1;
            powerfail_message_irq_n_o <= 1'b1;
        end else begin
            arbitration_error_irq_n_o <= ~(arb_error_i || // RULE_08
                (!arbitration_error_irq_n_o && !wr_pulse)); // RULE_20
            message_received_irq_n_o <= ~(msg_rx_valid_i || // RULE_09
                (!message_received_irq_n_o && !wr_pulse)); // RULE_20
            powerfail_message_irq_n_o <= ~((msg_rx_valid_i &&
                msg_rx_powerfail_i) || // RULE_10
                (!powerfail_message_irq_n_o && !wr_pulse)); // RULE_20
        end
    end

    // queue strobe, one cycle per received message
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            message_queue_strobe_n_o <= 1'b1;
        end else begin
            message_queue_strobe_n_o <= ~(msg_rx_valid_i && !soft_rst); // RULE_17
        end
    end

    // --------------------------------------------------------------------
    // idle bus arbitration and mastership
    // --------------------------------------------------------------------
    // compete window while idle arbitration runs and we request
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            idle_compete_window_n_o <= 1'b1;
        end else begin
            idle_compete_window_n_o <= ~(idle_arb_active_i && // RULE_11
                !idle_compete_request_n_i && !soft_rst);
        end
    end

    // remember competing until the idle arbitration ends
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            competed <= 1'b0;
        end else if (soft_rst || !idle_arb_active_i) begin
            competed <= 1'b0;
        end else if (!idle_compete_window_n_o) begin
            competed <= 1'b1;
        end
    end

    // success edge detector
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            win_prev <= 1'b1;
        end else begin
            win_prev <= idle_win_success_n_i;
        end
    end
    assign win_fall = win_prev && !idle_win_success_n_i;

    // master flag; an open window counts as having competed
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            master_o <= 1'b0;
        end else if (soft_rst) begin
            master_o <= 1'b0;
        end else if (win_fall && (competed || !idle_compete_window_n_o)) begin
            master_o <= 1'b1; // RULE_12
        end else if (win_fall && master_o) begin
            master_o <= 1'b0; // RULE_13
        end
    end

    // --------------------------------------------------------------------
    // lock handling at tenure transfer
    // --------------------------------------------------------------------
    // dummy cycle when master, unlock otherwise
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dummy_cycle_o <= 1'b0;
            release_locks_out_n_o <= 1'b1;
        end else begin
            dummy_cycle_o <= tenure_transfer_i && !resources_locked_in_n_i &&
                master_o && !soft_rst; // RULE_15
            release_locks_out_n_o <= ~(tenure_transfer_i && // RULE_16
                !resources_locked_in_n_i && !master_o && !soft_rst); // RULE_15
        end
    end

    // --------------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i || !host_rst_n_i);

    property p_drive_on_read;
        data_oe_o |-> rd_q && !transfer_ack_n_o;
    endproperty
    a_drive_on_read: assert property (p_drive_on_read) // RULE_01
        else $error("data bus driven outside a read ack");

    property p_ack_needs_cs;
        $fell(transfer_ack_n_o) |-> $past(!cs_n_i) && $past(!cs_n_i, 2);
    endproperty
    a_ack_needs_cs: assert property (p_ack_needs_cs) // RULE_03
        else $error("ack without chip select");

    property p_ack_each;
        (st == AHS_ST_IDLE && !cs_n_i) ##1 !cs_n_i |=> !transfer_ack_n_o;
    endproperty
    a_ack_each: assert property (p_ack_each) // RULE_04
        else $error("access not acknowledged in two cycles");

    property p_sel0_edge;
        wr_pulse && !capture_sel_i |=> $fell(transfer_ack_n_o);
    endproperty
    a_sel0_edge: assert property (p_sel0_edge) // RULE_05
        else $error("select low write not at ack edge");

    property p_sel1_edge;
        wr_pulse && capture_sel_i |-> cs_n_i && $past(!cs_n_i);
    endproperty
    a_sel1_edge: assert property (p_sel1_edge) // RULE_05
        else $error("select high write not at chip select rise");

    property p_sent;
        !message_sent_flag_n_o |-> $past(msg_tx_done_i) && $past(msg_pend);
    endproperty
    a_sent: assert property (p_sent) // RULE_07
        else $error("sent flag without transmission");

    property p_err;
        arb_error_i |=> !arbitration_error_irq_n_o;
    endproperty
    a_err: assert property (p_err) // RULE_08
        else $error("error interrupt missing");

    property p_rx;
        msg_rx_valid_i && !soft_rst |=> !message_received_irq_n_o &&
            !message_queue_strobe_n_o;
    endproperty
    a_rx: assert property (p_rx) // RULE_09
        else $error("receive interrupt or strobe missing");

    property p_pf;
        msg_rx_valid_i && msg_rx_powerfail_i |=> !powerfail_message_irq_n_o;
    endproperty
    a_pf: assert property (p_pf) // RULE_10
        else $error("powerfail interrupt missing");

    property p_win;
        win_fall && (competed || !idle_compete_window_n_o) |=> master_o;
    endproperty
    a_win: assert property (p_win) // RULE_12
        else $error("winner not made master");

    property p_lose;
        win_fall && !competed && idle_compete_window_n_o && master_o |=>
            !master_o;
    endproperty
    a_lose: assert property (p_lose) // RULE_13
        else $error("master flag not negated");

    property p_unlock;
        !release_locks_out_n_o |-> $past(!resources_locked_in_n_i);
    endproperty
    a_unlock: assert property (p_unlock) // RULE_16
        else $error("unlock without locked");

    property p_clear;
        wr_pulse && !arb_error_i ##1 1'b1 |-> arbitration_error_irq_n_o;
    endproperty
    a_clear: assert property (p_clear) // RULE_20
        else $error("write did not clear error interrupt");

    property p_ack_drop;
        !transfer_ack_n_o && cs_n_i |=> transfer_ack_n_o [*2];
    endproperty
    a_ack_drop: assert property (p_ack_drop) // RULE_21
        else $error("ack held after chip select release");

    c_read: cover property (!transfer_ack_n_o && data_oe_o);
    c_write: cover property (wr_pulse);
    c_rx_pf: cover property (msg_rx_valid_i && msg_rx_powerfail_i);
    c_unlock: cover property (!release_locks_out_n_o);

endmodule // ahs_host_if
`default_nettype wire

// file: dv/ahs_arb_model.sv
// far side model: answers a pending message send after a set delay
`timescale 1ns/100ps
`default_nettype none

module ahs_arb_model (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic msg_tx_req_i,
    input wire logic [3:0] delay_i,
    input wire logic fire_i,
    output logic msg_tx_done_o
);
    logic [3:0] cnt;
    logic done;

    // ------------------------------------------------------------
    // send completion timing
    // ------------------------------------------------------------
    // counts while a send is pending, drops the count on a cancel
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt <= 4'h0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!msg_tx_req_i) begin
                cnt <= 4'h0;
            end else if (cnt == delay_i) begin
                done <= 1'b1;
                cnt <= 4'h0;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end

    // fire_i forces a completion nobody asked for
    assign msg_tx_done_o = done | fire_i;
endmodule // ahs_arb_model

`default_nettype wire

// file: dv/test_ahs_host_if.sv
// testbench for the arbiter host side interface
`timescale 1ns/100ps
`default_nettype none

module test_ahs_host_if;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, hrst_n = 1'b1;
    logic [7:0] din = 8'h00, dout;
    logic [3:0] addr = 4'h0, dly = 4'h3;
    logic oe, cs_n = 1'b1, rw_n = 1'b1, ack_n, sel = 1'b0, req_n = 1'b1;
    logic txreq, txdone, fire = 1'b0, sent_n, err = 1'b0, err_n;
    logic rxv = 1'b0, rxpf = 1'b0, mirq_n, pirq_n, stb_n;
    logic iact = 1'b0, icmp_n = 1'b1, win_n, isucc_n = 1'b1, abort = 1'b0;
    logic tenure = 1'b0, lock_n = 1'b1, rel_n, dummy, master, phase0;
    logic [7:0] rd;
    int err_total = 0, n_compared = 0;

    ahs_host_if dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .host_rst_n_i(hrst_n), .data_i(din), .data_o(dout),
        .data_oe_o(oe), .addr_i(addr), .cs_n_i(cs_n), .rw_n_i(rw_n),
        .transfer_ack_n_o(ack_n), .capture_sel_i(sel),
        .message_send_request_n_i(req_n), .msg_tx_req_o(txreq),
        .msg_tx_done_i(txdone), .message_sent_flag_n_o(sent_n),
        .arb_error_i(err), .arbitration_error_irq_n_o(err_n),
        .msg_rx_valid_i(rxv), .msg_rx_powerfail_i(rxpf),
        .message_received_irq_n_o(mirq_n),
        .powerfail_message_irq_n_o(pirq_n),
        .message_queue_strobe_n_o(stb_n), .idle_arb_active_i(iact),
        .idle_compete_request_n_i(icmp_n), .idle_compete_window_n_o(win_n),
        .idle_win_success_n_i(isucc_n), .disconnect_or_abort_i(abort),
        .tenure_transfer_i(tenure), .resources_locked_in_n_i(lock_n),
        .release_locks_out_n_o(rel_n), .dummy_cycle_o(dummy),
        .master_o(master), .phase0_o(phase0));

    ahs_arb_model arb (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .msg_tx_req_i(txreq), .delay_i(dly), .fire_i(fire),
        .msg_tx_done_o(txdone));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, seen);
            err_total++;
        end
    endtask

    task automatic hang(input string what);
        $display("BAD %s expected handshake seen timeout", what);
        err_total++;
        print_verdict();
    endtask

    // one host access; data held until the acknowledge is gone
    task automatic acc(input logic rd_n, input logic [3:0] a,
                       input logic [7:0] wd, input logic s,
                       output logic [7:0] rdat);
        int n;
        @(negedge clk_i);
        cs_n = 1'b0;
        rw_n = rd_n;
        addr = a;
        din = wd;
        sel = s;
        n = 0;
        while (ack_n !== 1'b0) begin
            @(negedge clk_i);
            n++;
            if (n > 8) hang("ack_low");
        end
        check("ack_delay", 8'(n), 8'h02);
        check("oe_on", {7'h0, oe}, {7'h0, rd_n});
        rdat = dout;
        @(negedge clk_i);
        cs_n = 1'b1;
        n = 0;
        while (ack_n !== 1'b1) begin
            @(negedge clk_i);
            n++;
            if (n > 8) hang("ack_high");
        end
        check("oe_off", {7'h0, oe}, 8'h00);
        din = ~wd;
    endtask

    // one-cycle pulse on an event input, checked in the answer cycle
    task automatic pulse(ref logic sig);
        @(negedge clk_i);
        sig = 1'b1;
        @(negedge clk_i);
        sig = 1'b0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check("rst_outs", {ack_n, sent_n, err_n, mirq_n, pirq_n, stb_n,
              win_n, rel_n}, 8'hff);
        check("rst_lvl", {4'h0, oe, dummy, master, phase0}, 8'h01);
        $display("test reset done");
    endtask

    task automatic t_regs();
        acc(1'b0, 4'h3, 8'ha5, 1'b0, rd);
        acc(1'b0, 4'h4, 8'h5a, 1'b1, rd);
        acc(1'b1, 4'h3, 8'h00, 1'b0, rd);
        check("reg3", rd, 8'ha5);
        acc(1'b1, 4'h4, 8'h00, 1'b0, rd);
        check("reg4", rd, 8'h5a);
        // access dropped before the answer
        @(negedge clk_i);
        cs_n = 1'b0;
        rw_n = 1'b0;
        addr = 4'h5;
        din = 8'h77;
        @(negedge clk_i);
        cs_n = 1'b1;
        repeat (3) begin
            @(negedge clk_i);
            check("abort_ack", {7'h0, ack_n}, 8'h01);
        end
        acc(1'b1, 4'h5, 8'h00, 1'b0, rd);
        check("abort_wr", rd, 8'h00);
        acc(1'b1, 4'hf, 8'h00, 1'b0, rd);
        check("status", rd & 8'h0f, 8'h08);
        $display("test regs done");
    endtask

    task automatic t_events();
        pulse(rxv);
        check("stb", {5'h0, stb_n, mirq_n, pirq_n}, 8'h01);
        @(negedge clk_i);
        check("stb_end", {7'h0, stb_n}, 8'h01);
        rxpf = 1'b1;
        pulse(rxv);
        rxpf = 1'b0;
        check("pf", {7'h0, pirq_n}, 8'h00);
        pulse(err);
        check("err", {7'h0, err_n}, 8'h00);
        acc(1'b0, 4'h9, 8'h11, 1'b0, rd);
        check("irq_clr", {5'h0, err_n, mirq_n, pirq_n}, 8'h07);
        $display("test events done");
    endtask

    task automatic t_send();
        int n;
        dly = 4'h3;
        req_n = 1'b0;
        @(negedge clk_i);
        req_n = 1'b1;
        @(negedge clk_i);
        check("txreq", {6'h0, txreq, phase0}, 8'h02);
        n = 0;
        while (sent_n !== 1'b0) begin
            @(negedge clk_i);
            n++;
            if (n > 12) hang("sent");
        end
        @(negedge clk_i);
        check("sent_end", {7'h0, sent_n}, 8'h01);
        pulse(fire);
        check("no_send", {7'h0, sent_n}, 8'h01);
        dly = 4'hc;
        req_n = 1'b0;
        @(negedge clk_i);
        req_n = 1'b1;
        pulse(abort);
        check("cancel", {7'h0, txreq}, 8'h00);
        n = 0;
        repeat (16) begin
            @(negedge clk_i);
            if (sent_n !== 1'b1) n++;
        end
        check("cancel_sent", 8'(n), 8'h00);
        req_n = 1'b0;
        @(negedge clk_i);
        req_n = 1'b1;
        hrst_n = 1'b0;
        @(negedge clk_i);
        hrst_n = 1'b1;
        check("hrst", {6'h0, txreq, phase0}, 8'h01);
        $display("test send done");
    endtask

    task automatic t_idle_lock();
        @(negedge clk_i);
        iact = 1'b1;
        icmp_n = 1'b0;
        @(negedge clk_i);
        check("window", {7'h0, win_n}, 8'h00);
        isucc_n = 1'b0;
        repeat (2) @(negedge clk_i);
        check("win_master", {7'h0, master}, 8'h01);
        isucc_n = 1'b1;
        icmp_n = 1'b1;
        iact = 1'b0;
        @(negedge clk_i);
        check("win_off", {7'h0, win_n}, 8'h01);
        lock_n = 1'b0;
        pulse(tenure);
        check("dummy", {6'h0, dummy, rel_n}, 8'h03);
        @(negedge clk_i);
        check("dummy_end", {7'h0, dummy}, 8'h00);
        iact = 1'b1;
        isucc_n = 1'b0;
        repeat (2) @(negedge clk_i);
        check("lose_master", {7'h0, master}, 8'h00);
        isucc_n = 1'b1;
        iact = 1'b0;
        pulse(tenure);
        check("unlock", {6'h0, dummy, rel_n}, 8'h00);
        lock_n = 1'b1;
        pulse(tenure);
        check("no_unlock", {7'h0, rel_n}, 8'h01);
        $display("test idle lock done");
    endtask

    // ------------------------------------------------------------
    // clock, reset and sequence
    // ------------------------------------------------------------
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    initial begin
        repeat (6) @(negedge clk_i);
        sys_rst_i = 1'b0;
        @(negedge clk_i);
        t_reset();
        t_regs();
        t_events();
        t_send();
        t_idle_lock();
        print_verdict();
    end
endmodule // test_ahs_host_if

`default_nettype wire
